/* File: pkg/timer_map.svh */
// Operation
// - Mode 00/01 keeps channels 3, 4 independent
// - Mode 10 joins channels 3, 4 complementary
// - Mode 11 joins channels 3, 4 reset-synchronized
// - A code 000 compares, pin unchanged
// - A code 001 drives A low on match
// - A code 010 drives A high on match
// - A code 011 toggles A on match
// - A codes 100/101 capture rising/falling edge
// - A code 11x captures both edges
// - B codes 000-011 pick compare output action
// - B codes 100/101/11x capture on edges
// - Counter wrap FFFF to 0000 sets overflow
// - Flag writes only clear, ones ignored
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_COUNTER_CONTROL 8'h64
`define IDX_PIN_FUNCTION 8'h65
`define IDX_IRQ_MASK 8'h66
`define IDX_STATUS 8'h67
`define IDX_COUNTER 8'h68
`define IDX_GENERAL_A 8'h6A
`define IDX_GENERAL_B 8'h6C
`define IDX_FUNCTION 8'h73

// Field positions
`define POS_FLAG_A 0
`define POS_FLAG_B 1
`define POS_FLAG_OVF 2
`define POS_COMB_LO 4
`define POS_COMB_HI 5
`define POS_MODE_A 0
`define POS_MODE_B 4
`define POS_CLOCK_SEL 0
`define POS_EDGE_SEL 3
`define POS_CLEAR_SEL 5

// Reset values and read-as-one masks of reserved bits
`define RST_COUNTER_CONTROL 8'h80
`define RST_PIN_FUNCTION 8'h88
`define RST_FUNCTION 8'hC0
`define RST_GENERAL 16'hFFFF
`define RST_COUNTER 16'h0000
`define ONES_STATUS 8'hF8
`define ONES_COUNTER_CONTROL 8'h80
`define ONES_PIN_FUNCTION 8'h88
`define ONES_FUNCTION 8'hCF
`define COUNT_MAX 16'hFFFF

`endif

/* File: pkg/timer_pkg.sv */
package timer_pkg;

  typedef logic [15:0] count_type;

  typedef enum logic [1:0] {
    clear_none_type = 2'h0,
    clear_on_a_type = 2'h1,
    clear_on_b_type = 2'h2,
    clear_sync_type = 2'h3
  } clear_source_type;

  typedef enum logic [1:0] {
    comb_normal_type = 2'h0,
    comb_normal_alt_type = 2'h1,
    comb_complementary_type = 2'h2,
    comb_reset_sync_type = 2'h3
  } comb_mode_type;

endpackage : timer_pkg

/* File: hdl/count_tick.sv */
`timescale 1ns/1ps
module count_tick (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] clock_select,
  input wire logic [1:0] edge_select,
  input wire logic [3:0] ext_clk,
  output logic tick
);

  logic [2:0] divider;
  logic ext_prev;
  logic ext_now;
  logic int_tick;
  logic ext_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider <= 3'h0;
    end else begin
      divider <= divider + 3'h1;
    end
  end

  // Internal rates 1, 1/2, 1/4, 1/8 of pclk
  always_comb begin
    case (clock_select[1:0])
      2'h0: int_tick = 1'b1;
      2'h1: int_tick = divider[0];
      2'h2: int_tick = &divider[1:0];
      default: int_tick = &divider;
    endcase
  end

  assign ext_now = ext_clk[clock_select[1:0]];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_now;
    end
  end

  always_comb begin
    case (edge_select)
      2'h0: ext_tick = ext_now & ~ext_prev;
      2'h1: ext_tick = ~ext_now & ext_prev;
      default: ext_tick = ext_now ^ ext_prev;
    endcase
  end

  assign tick = clock_select[2] ? ext_tick : int_tick;

endmodule : count_tick

/* File: hdl/compare_capture.sv */
`timescale 1ns/1ps
module compare_capture (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] mode,
  input wire logic tick,
  input wire timer_pkg::count_type counter,
  input wire timer_pkg::count_type general,
  input wire logic pin_in,
  output logic match,
  output logic capture,
  output logic pin_out
);

  logic pin_prev;
  logic rise;
  logic fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_in;
    end
  end

  assign rise = pin_in & ~pin_prev;
  assign fall = ~pin_in & pin_prev;

  // Compare only on a count tick so a held value matches once
  assign match = ~mode[2] & tick & (counter == general);

  always_comb begin
    case (mode[1:0])
      2'h0: capture = mode[2] & rise;
      2'h1: capture = mode[2] & fall;
      default: capture = mode[2] & (rise | fall);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
    end else if (match) begin
      case (mode[1:0])
        2'h1: pin_out <= 1'b0;
        2'h2: pin_out <= 1'b1;
        2'h3: pin_out <= ~pin_out;
        default: pin_out <= pin_out;
      endcase
    end
  end

endmodule : compare_capture

/* File: hdl/timer_channel.sv */
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "timer_map.svh"
module timer_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] ext_clk,
  input wire logic sync_clear,
  input wire logic capture_in_a,
  input wire logic capture_in_b,
  output logic compare_out_a,
  output logic compare_out_b,
  output logic complementary_pwm,
  output logic reset_sync_pwm,
  output logic counter_cleared,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [7:0] counter_control;
  logic [7:0] pin_function;
  logic [7:0] function_control;
  logic [2:0] irq_mask;
  logic [2:0] flags;
  logic [2:0] read_armed;
  timer_pkg::count_type counter;
  timer_pkg::count_type general_a;
  timer_pkg::count_type general_b;

  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic tick;
  logic match_a;
  logic match_b;
  logic cap_a;
  logic cap_b;
  logic pin_a;
  logic pin_b;
  logic clear_hit;
  logic wrap;
  logic [2:0] events;
  logic [2:0] flag_clear;
  logic [31:0] next_prdata;
  logic next_slverr;
  timer_pkg::clear_source_type clear_source;
  timer_pkg::comb_mode_type comb_mode;
  logic lane0_wr;
  logic sel_counter_control;
  logic sel_pin_function;
  logic sel_irq_mask;
  logic sel_status;
  logic sel_counter;
  logic sel_general_a;
  logic sel_general_b;
  logic sel_function;

  // Decode reused by read mux, writes and error response
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] index);
    hit = (addr[31:10] == 22'h0) && (addr[9:2] == index) && (addr[1:0] == 2'h0);
  endfunction : hit

  function automatic logic mapped(input logic [31:0] addr);
    mapped = hit(addr, `IDX_COUNTER_CONTROL) || hit(addr, `IDX_PIN_FUNCTION) ||
             hit(addr, `IDX_IRQ_MASK) || hit(addr, `IDX_STATUS) ||
             hit(addr, `IDX_COUNTER) || hit(addr, `IDX_GENERAL_A) ||
             hit(addr, `IDX_GENERAL_B) || hit(addr, `IDX_FUNCTION);
  endfunction : mapped

  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr = access & pwrite & ~pslverr;
  assign rd = access & ~pwrite & ~pslverr;
  assign clear_source = timer_pkg::clear_source_type'(counter_control[`POS_CLEAR_SEL +: 2]);
  assign comb_mode = timer_pkg::comb_mode_type'(function_control[`POS_COMB_LO +: 2]);
  assign lane0_wr = wr & pstrb[0];

  // One select per register so the read mux and every writer agree
  assign sel_counter_control = hit(paddr, `IDX_COUNTER_CONTROL);
  assign sel_pin_function = hit(paddr, `IDX_PIN_FUNCTION);
  assign sel_irq_mask = hit(paddr, `IDX_IRQ_MASK);
  assign sel_status = hit(paddr, `IDX_STATUS);
  assign sel_counter = hit(paddr, `IDX_COUNTER);
  assign sel_general_a = hit(paddr, `IDX_GENERAL_A);
  assign sel_general_b = hit(paddr, `IDX_GENERAL_B);
  assign sel_function = hit(paddr, `IDX_FUNCTION);

  ////////////////////////////////////////////////////////////////////////////////
  // APB response, zero wait states

  always_comb begin
    next_prdata = 32'h0;
    next_slverr = 1'b0;
    if (sel_counter_control) begin
      next_prdata[7:0] = counter_control | `ONES_COUNTER_CONTROL;
    end else if (sel_pin_function) begin
      next_prdata[7:0] = pin_function | `ONES_PIN_FUNCTION;
    end else if (sel_irq_mask) begin
      next_prdata[2:0] = irq_mask;
    end else if (sel_status) begin
      next_prdata[7:0] = {5'h1F, flags};
    end else if (sel_counter) begin
      next_prdata[15:0] = counter;
    end else if (sel_general_a) begin
      next_prdata[15:0] = general_a;
    end else if (sel_general_b) begin
      next_prdata[15:0] = general_b;
    end else if (sel_function) begin
      next_prdata[7:0] = function_control | `ONES_FUNCTION;
    end else begin
      next_slverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      // Zero wait states: the answer always stands in the cycle after setup
      pready <= setup;
      pslverr <= setup & next_slverr;
      prdata <= (setup & ~pwrite) ? next_prdata : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers; only byte lane 0 holds 8-bit fields

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_control <= `RST_COUNTER_CONTROL;
    end else if (lane0_wr && sel_counter_control) begin
      counter_control <= pwdata[7:0] | `ONES_COUNTER_CONTROL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_function <= `RST_PIN_FUNCTION;
    end else if (lane0_wr && sel_pin_function) begin
      pin_function <= pwdata[7:0] | `ONES_PIN_FUNCTION;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_control <= `RST_FUNCTION;
    end else if (lane0_wr && sel_function) begin
      function_control <= pwdata[7:0] | `ONES_FUNCTION;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= 3'h0;
    end else if (lane0_wr && sel_irq_mask) begin
      irq_mask <= pwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel 3/4 coupling signals

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      complementary_pwm <= 1'b0;
      reset_sync_pwm <= 1'b0;
    end else begin
      case (comb_mode)
        timer_pkg::comb_complementary_type: begin
          complementary_pwm <= 1'b1;
          reset_sync_pwm <= 1'b0;
        end
        timer_pkg::comb_reset_sync_type: begin
          complementary_pwm <= 1'b0;
          reset_sync_pwm <= 1'b1;
        end
        timer_pkg::comb_normal_type, timer_pkg::comb_normal_alt_type: begin
          complementary_pwm <= 1'b0;
          reset_sync_pwm <= 1'b0;
        end
        default: begin
          complementary_pwm <= 1'b0;
          reset_sync_pwm <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter

  count_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clock_select(counter_control[`POS_CLOCK_SEL +: 3]),
    .edge_select(counter_control[`POS_EDGE_SEL +: 2]),
    .ext_clk(ext_clk),
    .tick(tick)
  );

  always_comb begin
    case (clear_source)
      timer_pkg::clear_on_a_type: clear_hit = match_a | cap_a;
      timer_pkg::clear_on_b_type: clear_hit = match_b | cap_b;
      timer_pkg::clear_sync_type: clear_hit = sync_clear;
      default: clear_hit = 1'b0;
    endcase
  end

  // A clear on the wrapping tick still counts as overflow
  assign wrap = tick & (counter == `COUNT_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= `RST_COUNTER;
    end else if (wr && sel_counter) begin
      counter <= pwdata[15:0];
    end else if (clear_hit) begin
      counter <= `RST_COUNTER;
    end else if (tick) begin
      counter <= counter + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_cleared <= 1'b0;
    end else begin
      counter_cleared <= clear_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // General registers

  compare_capture u_unit_a (
    .pclk(pclk),
    .presetn(presetn),
    .mode(pin_function[`POS_MODE_A +: 3]),
    .tick(tick),
    .counter(counter),
    .general(general_a),
    .pin_in(capture_in_a),
    .match(match_a),
    .capture(cap_a),
    .pin_out(pin_a)
  );

  compare_capture u_unit_b (
    .pclk(pclk),
    .presetn(presetn),
    .mode(pin_function[`POS_MODE_B +: 3]),
    .tick(tick),
    .counter(counter),
    .general(general_b),
    .pin_in(capture_in_b),
    .match(match_b),
    .capture(cap_b),
    .pin_out(pin_b)
  );

  // Capture beats a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_a <= `RST_GENERAL;
    end else if (cap_a) begin
      general_a <= counter;
    end else if (wr && sel_general_a) begin
      general_a <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_b <= `RST_GENERAL;
    end else if (cap_b) begin
      general_b <= counter;
    end else if (wr && sel_general_b) begin
      general_b <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_out_a <= 1'b0;
      compare_out_b <= 1'b0;
    end else begin
      compare_out_a <= pin_a;
      compare_out_b <= pin_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status flags and interrupt

  assign events[`POS_FLAG_A] = match_a | cap_a;
  assign events[`POS_FLAG_B] = match_b | cap_b;
  assign events[`POS_FLAG_OVF] = wrap;

  // Only a zero written to a bit already read as one clears it
  assign flag_clear = (lane0_wr && sel_status) ?
                      (~pwdata[2:0] & read_armed) : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_armed <= 3'h0;
    end else if (rd && sel_status) begin
      read_armed <= flags;
    end else begin
      read_armed <= read_armed & ~flag_clear;
    end
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 3'h0;
    end else begin
      flags <= (flags & ~flag_clear) | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & irq_mask);
    end
  end

endmodule : timer_channel

/* File: verification/ext_side.sv */
`timescale 1ns/1ps
module ext_side (
  input wire logic pclk,
  output logic [3:0] ext_clk,
  output logic sync_clear,
  output logic capture_in_a,
  output logic capture_in_b
);
  // External clock rests low between bursts, as a real source would
  initial begin
    ext_clk = 4'h0;
    sync_clear = 1'b0;
    capture_in_a = 1'b0;
    capture_in_b = 1'b0;
  end
  task automatic set_cap(input int ch, input logic lvl);
    @(posedge pclk);
    if (ch == 1) capture_in_b <= lvl;
    else capture_in_a <= lvl;
    repeat (3) @(posedge pclk);
  endtask : set_cap
  // Three cycles high and four low per pulse so every edge is seen by the synchroniser
  task automatic pulses(input int n, input int idx);
    repeat (n) begin
      @(posedge pclk);
      ext_clk[idx] <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_clk[idx] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask : pulses
  task automatic sync_pulse();
    @(posedge pclk);
    sync_clear <= 1'b1;
    @(posedge pclk);
    sync_clear <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : sync_pulse
endmodule : ext_side

/* File: verification/timer_channel_properties.sv */
`timescale 1ns/1ps
`include "timer_map.svh"
module timer_channel_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic sync_clear,
  input wire logic compare_out_a,
  input wire logic compare_out_b,
  input wire logic complementary_pwm,
  input wire logic reset_sync_pwm,
  input wire logic counter_cleared
);
  logic acc;
  logic wr_fn;
  logic [2:0] mode_a;
  logic [2:0] mode_b;
  logic [1:0] age;
  logic [1:0] clr_sel;
  assign acc = psel && penable && pready && pwrite && pstrb[0];
  assign wr_fn = acc && paddr == `IDX_FUNCTION * 4;
  ////////////////////////////////////////
  // Shadow settings; age lets a match already in flight land before judging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_a <= 3'h0;
      mode_b <= 3'h0;
      age <= 2'h3;
    end else if (acc && paddr == `IDX_PIN_FUNCTION * 4) begin
      mode_a <= pwdata[2:0];
      mode_b <= pwdata[6:4];
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clr_sel <= 2'h0;
    else if (acc && paddr == `IDX_COUNTER_CONTROL * 4) clr_sel <= pwdata[6:5];
  end
  ////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no zero wait answer");
  property p_rd0; !pready |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside access");
  property p_norm; wr_fn && !pwdata[5] |-> ##[1:2] !complementary_pwm && !reset_sync_pwm;
  endproperty
  a_norm: assert property (p_norm) else $error("pwm in normal mode");
  property p_comp; wr_fn && pwdata[5:4] == 2'h2 |-> ##[1:2] complementary_pwm && !reset_sync_pwm;
  endproperty
  a_comp: assert property (p_comp) else $error("no complementary mode");
  property p_rsync; wr_fn && pwdata[5:4] == 2'h3 |-> ##[1:2] reset_sync_pwm && !complementary_pwm;
  endproperty
  a_rsync: assert property (p_rsync) else $error("no reset sync mode");
  property p_keep; age == 2'h3 && mode_a == 3'h0 |-> $stable(compare_out_a); endproperty
  a_keep: assert property (p_keep) else $error("output a moved");
  property p_low; age == 2'h3 && mode_a == 3'h1 |-> !$rose(compare_out_a); endproperty
  a_low: assert property (p_low) else $error("output a rose");
  property p_high; age == 2'h3 && mode_a == 3'h2 |-> !$fell(compare_out_a); endproperty
  a_high: assert property (p_high) else $error("output a fell");
  property p_low_b; age == 2'h3 && mode_b == 3'h1 |-> !$rose(compare_out_b); endproperty
  a_low_b: assert property (p_low_b) else $error("output b rose");
  property p_sync; clr_sel == 2'h3 && sync_clear |-> ##[1:2] counter_cleared; endproperty
  a_sync: assert property (p_sync) else $error("no sync clear");
endmodule : timer_channel_checker
bind timer_channel timer_channel_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .sync_clear, .compare_out_a, .compare_out_b,
  .complementary_pwm, .reset_sync_pwm, .counter_cleared);

/* File: verification/tb.sv */
`timescale 1ns/1ps
`include "timer_map.svh"
module tb;
  typedef struct packed {
    logic [31:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
    logic r;
  } row_type;
  localparam logic [31:0] cc_ad = `IDX_COUNTER_CONTROL * 4;
  localparam logic [31:0] pf_ad = `IDX_PIN_FUNCTION * 4;
  localparam logic [31:0] mk_ad = `IDX_IRQ_MASK * 4;
  localparam logic [31:0] st_ad = `IDX_STATUS * 4;
  localparam logic [31:0] cn_ad = `IDX_COUNTER * 4;
  localparam logic [31:0] ga_ad = `IDX_GENERAL_A * 4;
  localparam logic [31:0] gb_ad = `IDX_GENERAL_B * 4;
  localparam logic [31:0] fn_ad = `IDX_FUNCTION * 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb, ext_clk;
  logic sync_clear, capture_in_a, capture_in_b, compare_out_a, compare_out_b;
  logic complementary_pwm, reset_sync_pwm, counter_cleared, irq;
  int n_mismatch = 0;
  int checks = 0;
  row_type rows [15] = '{
    '{cc_ad, 1'b0, 32'h0, 32'h80, 1'b0}, '{pf_ad, 1'b0, 32'h0, 32'h88, 1'b0},
    '{fn_ad, 1'b0, 32'h0, 32'hCF, 1'b0}, '{st_ad, 1'b0, 32'h0, 32'hF8, 1'b0},
    '{mk_ad, 1'b0, 32'h0, 32'h0, 1'b0}, '{ga_ad, 1'b0, 32'h0, 32'hFFFF, 1'b0},
    '{gb_ad, 1'b0, 32'h0, 32'hFFFF, 1'b0}, '{fn_ad, 1'b1, 32'h00, 32'hCF, 1'b0},
    '{fn_ad, 1'b1, 32'h10, 32'hDF, 1'b0}, '{fn_ad, 1'b1, 32'h20, 32'hEF, 1'b0},
    '{fn_ad, 1'b1, 32'h30, 32'hFF, 1'b0}, '{cc_ad, 1'b1, 32'h7F, 32'hFF, 1'b0},
    '{mk_ad, 1'b1, 32'h7, 32'h7, 1'b0}, '{32'h0, 1'b0, 32'h0, 32'h0, 1'b1},
    '{32'h191, 1'b0, 32'h0, 32'h0, 1'b1}};
  timer_channel dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .ext_clk, .sync_clear, .capture_in_a, .capture_in_b,
    .compare_out_a, .compare_out_b, .complementary_pwm, .reset_sync_pwm, .counter_cleared, .irq);
  ext_side ext (.pclk, .ext_clk, .sync_clear, .capture_in_a, .capture_in_b);
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_word
  task automatic cmp_pin(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_pin
  // Request held until pready is sampled; the wait has no bound of its own
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No bound here: the watchdog alone ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] x,
                     input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp_word(nm, x, r & m);
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  function automatic logic pin(input int ch);
    return ch == 1 ? compare_out_b : compare_out_a;
  endfunction : pin
  task automatic period(input int ch, output logic [31:0] n);
    logic v;
    int k;
    v = pin(ch);
    k = 0;
    while (pin(ch) === v && k < 200) begin
      @(posedge pclk);
      k++;
    end
    v = pin(ch);
    n = 0;
    while (pin(ch) === v && n < 200) begin
      @(posedge pclk);
      n++;
    end
  endtask : period
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    logic [31:0] v, g;
    logic e;
    int sh;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    cyc(4);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0, v, e);
      cmp_word("rdata", rows[i].e, v);
      cmp_pin("slverr", rows[i].r, e);
    end
    wr(mk_ad, 32'h0);
    for (int ch = 0; ch < 2; ch++) begin
      sh = ch * 4;
      g = ch == 1 ? gb_ad : ga_ad;
      wr(cc_ad, ch == 1 ? 32'h40 : 32'h20);
      wr(g, 32'h40);
      wr(cn_ad, 32'h0);
      wr(pf_ad, 32'h2 << sh);
      cyc(90);
      cmp_pin("out_high", 1'b1, pin(ch));
      wr(pf_ad, 32'h1 << sh);
      cyc(90);
      cmp_pin("out_low", 1'b0, pin(ch));
      wr(pf_ad, 32'h3 << sh);
      period(ch, v);
      cmp_word("toggle_period", 32'h41, v);
      wr(pf_ad, 32'h0);
      cyc(4);
      e = pin(ch);
      cyc(140);
      cmp_pin("out_keep", e, pin(ch));
    end
    // Slower internal rates stretch the toggle period by the divide ratio
    wr(ga_ad, 32'h10);
    wr(pf_ad, 32'h3);
    for (int cs = 1; cs < 4; cs++) begin
      wr(cc_ad, 32'h20 | cs);
      wr(cn_ad, 32'h0);
      cyc(4);
      period(0, v);
      cmp_word("prescale_period", 32'h11 << cs, v);
    end
    // Stopped external clock freezes the counter, so capture values are exact
    wr(cc_ad, 32'h04);
    for (int ch = 0; ch < 2; ch++) begin
      g = ch == 1 ? gb_ad : ga_ad;
      for (int m = 4; m < 8; m++) begin
        wr(pf_ad, m << (ch * 4));
        wr(g, 32'h0);
        wr(cn_ad, 32'h1234);
        ext.set_cap(ch, 1'b1);
        chk(g, 32'hFFFF, m == 5 ? 32'h0 : 32'h1234, "cap_rise");
        wr(cn_ad, 32'h2222);
        ext.set_cap(ch, 1'b0);
        chk(g, 32'hFFFF, m == 4 ? 32'h1234 : 32'h2222, "cap_fall");
      end
    end
    for (int es = 0; es < 4; es++) begin
      // Each edge setting also counts from a different external input
      wr(cc_ad, 32'h04 | es | (es << 3));
      wr(cn_ad, 32'h0);
      ext.pulses(5, es);
      chk(cn_ad, 32'hFFFF, es > 1 ? 32'hA : 32'h5, "ext_edges");
    end
    wr(cc_ad, 32'h64);
    wr(cn_ad, 32'h55);
    ext.sync_pulse();
    chk(cn_ad, 32'hFFFF, 32'h0, "sync_clear");
    wr(cc_ad, 32'h04);
    wr(cn_ad, 32'hFFFF);
    ext.pulses(1, 0);
    chk(cn_ad, 32'hFFFF, 32'h0, "wrap");
    chk(st_ad, 32'h4, 32'h4, "ovf_set");
    cmp_pin("irq_masked", 1'b0, irq);
    wr(mk_ad, 32'h4);
    cyc(3);
    cmp_pin("irq_on", 1'b1, irq);
    wr(st_ad, 32'hFF);
    chk(st_ad, 32'h4, 32'h4, "ovf_keep");
    wr(st_ad, 32'hFB);
    chk(st_ad, 32'h4, 32'h0, "ovf_clear");
    cyc(3);
    cmp_pin("irq_off", 1'b0, irq);
    wr(cn_ad, 32'hFFFF);
    ext.pulses(1, 0);
    cyc(3);
    cmp_pin("irq_again", 1'b1, irq);
    wr(st_ad, 32'h0);
    chk(st_ad, 32'h4, 32'h4, "ovf_unread");
    presetn <= 1'b0;
    cyc(2);
    cmp_pin("irq_reset", 1'b0, irq);
    presetn <= 1'b1;
    chk(pf_ad, 32'hFFFFFFFF, 32'h88, "pf_reset");
    chk(st_ad, 32'hFFFFFFFF, 32'hF8, "status_reset");
    end_of_test();
  end
endmodule : tb
